// ### include/host_port_pkg.sv
// constants shared by the host port decode and status override block
package host_port_pkg;
    // apb register byte offsets
    localparam logic [7:0]  OFF_STRAP      = 8'h00;
    localparam logic [7:0]  OFF_CTRL       = 8'h04;
    localparam logic [7:0]  OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0]  OFF_IRQ_CLEAR  = 8'h0c;
    localparam logic [7:0]  OFF_IRQ_ENABLE = 8'h10;

    // control register layout and reset value
    localparam int          CTRL_DECODE_EN = 0;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0001;

    // event bits, shared by irq status, clear and enable registers
    localparam int          EV_HIT     = 0;
    localparam int          EV_REFUSED = 1;
    localparam int          EV_IRQ     = 2;
    localparam int          EV_W       = 3;
    localparam logic [2:0]  IRQ_EN_RST = 3'h0;

    // host i/o windows: address lines 9..3 of 3f8 and 2f8
    localparam logic [6:0]  WIN_BASE_PRIMARY   = 7'h7f;
    localparam logic [6:0]  WIN_BASE_SECONDARY = 7'h5f;

    // positions of the pin levels in the synchroniser vector
    localparam int          PIN_CD_OVR  = 0;
    localparam int          PIN_TR_OVR  = 1;
    localparam int          PIN_DEC_EN  = 2;
    localparam int          PIN_WIN_SEL = 3;
    localparam int          PIN_DMA     = 4;
    localparam int          PIN_HIGH_Q  = 5;
    localparam int          PIN_EXT_SEL = 6;
    localparam int          PIN_RD      = 7;
    localparam int          PIN_WR      = 8;
    localparam int          PIN_ADDR    = 9;
    localparam int          PIN_W       = 19;
    // idle levels: pulled-up straps high, strobes idle high, no dma
    localparam logic [18:0] PIN_RST     = 19'h001ef;
endpackage

// ### src/host_port_decode.sv
// host address decoder, status bit overrides and interrupt pin steering
//
// Summary of operation
// [R1] With the carrier-detect override low, host status bit 7 follows the controller's value.
// [R2] With the carrier-detect override high, host status bit 7 reads as 1.
// [R3] With the terminal-ready override low, controller register bit 6 follows the host's value.
// [R4] With the terminal-ready override high, controller register bit 6 reads as 1.
// [R5] With the external decoder, a host access is allowed only while the external select is low.
// [R6] The internal decoder is used when its enable pin is high and bypassed when it is low.
// [R7] A system bypassing the internal decoder drives its enable low and ties address 9..3.
// [R8] Window select low decodes 3f8-3ff and drives only the primary interrupt pin.
// [R9] Window select high decodes 2f8-2ff and drives only the secondary interrupt pin.
// [R10] The selected interrupt pin drives only while the interrupt line enable bit is 1.
// [R11] No address is decoded while the dma bus owner input is high.
// [R12] No address is decoded while the high address qualifier is low.
// [R13] The internal decoder matches address 9..3 to the window base and indexes with 2..0.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module host_port_decode
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // host pins, asynchronous to ref_clk
    input  wire logic        carrier_detect_override,
    input  wire logic        terminal_ready_override,
    input  wire logic        internal_decoder_enable,
    input  wire logic        port_window_select,
    input  wire logic        dma_bus_owner,
    input  wire logic        high_address_qualify,
    input  wire logic        ext_select_n,
    input  wire logic        host_rd_n,
    input  wire logic        host_wr_n,
    input  wire logic [9:0]  host_addr,
    // register-side values, same clock
    input  wire logic        ctrl_carrier_detect,
    input  wire logic        host_terminal_ready,
    input  wire logic        irq_line_enable_bit,
    input  wire logic        irq_request,
    // results
    output logic             carrier_detect_bit,
    output logic             terminal_ready_bit,
    output logic             host_reg_select,
    output logic [2:0]       host_reg_index,
    output logic             irq_out_primary,
    output logic             irq_out_primary_oe,
    output logic             irq_out_secondary,
    output logic             irq_out_secondary_oe,
    output logic             irq
);

    // window match on address lines 9..3
    function automatic logic window_hit(input logic [9:0] a, input logic sel);
        window_hit = (a[9:3] == (sel ? host_port_pkg::WIN_BASE_SECONDARY
                                     : host_port_pkg::WIN_BASE_PRIMARY));
    endfunction

    logic [host_port_pkg::PIN_W-1:0] pin_meta_r;
    logic [host_port_pkg::PIN_W-1:0] pin_r;
    logic                            cd_ovr;
    logic                            tr_ovr;
    logic                            dec_en;
    logic                            win_sel;
    logic                            dma;
    logic                            high_q;
    logic                            ext_sel_n;
    logic                            strobe;
    logic [9:0]                      addr;
    logic                            addr_ok;
    logic                            access_ok;
    logic                            refused;
    logic [31:0]                     ctrl_r;
    logic [host_port_pkg::EV_W-1:0]  irq_status_r;
    logic [host_port_pkg::EV_W-1:0]  irq_enable_r;
    logic [host_port_pkg::EV_W-1:0]  ev_set;
    logic [host_port_pkg::EV_W-1:0]  ev_clr;
    logic                            cd_bit_r;
    logic                            tr_bit_r;
    logic                            sel_r;
    logic [2:0]                      index_r;
    logic                            irq_p_r;
    logic                            irq_p_oe_r;
    logic                            irq_s_r;
    logic                            irq_s_oe_r;
    logic                            irq_req_d_r;
    logic                            irq_r;
    logic [31:0]                     prdata_r;
    logic                            pready_r;
    logic                            pslverr_r;
    logic                            apb_access;
    logic                            apb_done;
    logic                            addr_mapped;
    logic [31:0]                     rd_mux;

    // pins pass two flops before any logic reads them
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_meta_r <= host_port_pkg::PIN_RST;
            pin_r      <= host_port_pkg::PIN_RST;
        end
        else
        begin
            pin_meta_r <= {host_addr, host_wr_n, host_rd_n, ext_select_n, high_address_qualify,
                           dma_bus_owner, port_window_select, internal_decoder_enable,
                           terminal_ready_override, carrier_detect_override};
            pin_r      <= pin_meta_r;
        end
    end

    assign cd_ovr    = pin_r[host_port_pkg::PIN_CD_OVR];
    assign tr_ovr    = pin_r[host_port_pkg::PIN_TR_OVR];
    assign dec_en    = pin_r[host_port_pkg::PIN_DEC_EN];
    assign win_sel   = pin_r[host_port_pkg::PIN_WIN_SEL];
    assign dma       = pin_r[host_port_pkg::PIN_DMA];
    assign high_q    = pin_r[host_port_pkg::PIN_HIGH_Q];
    assign ext_sel_n = pin_r[host_port_pkg::PIN_EXT_SEL];
    assign strobe    = !pin_r[host_port_pkg::PIN_RD] || !pin_r[host_port_pkg::PIN_WR];
    assign addr      = pin_r[host_port_pkg::PIN_ADDR +: 10];

    // internal decoder or external select; a bypassed decoder ignores address 9..3,
    // which the host side must tie (see [R7])
    assign addr_ok   = dec_en ? window_hit(addr, win_sel)   // see [R6] see [R13]
                              : !ext_sel_n;                  // see [R5]
    // dma cycles and an unqualified high address block every decode (see [R11] see [R12])
    assign access_ok = strobe && addr_ok && !dma && high_q && ctrl_r[host_port_pkg::CTRL_DECODE_EN];
    assign refused   = strobe && addr_ok && (dma || !high_q);

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_r   <= 1'b0;
            index_r <= 3'h0;
        end
        else
        begin
            sel_r   <= access_ok;
            index_r <= access_ok ? addr[2:0] : 3'h0;   // see [R13]
        end
    end

    // status overrides force the bit high whatever the writer set
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cd_bit_r <= 1'b0;
            tr_bit_r <= 1'b0;
        end
        else
        begin
            cd_bit_r <= cd_ovr | ctrl_carrier_detect;   // see [R1] see [R2]
            tr_bit_r <= tr_ovr | host_terminal_ready;   // see [R3] see [R4]
        end
    end

    // only one interrupt pin ever drives; the other stays released
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_p_r    <= 1'b0;
            irq_p_oe_r <= 1'b0;
            irq_s_r    <= 1'b0;
            irq_s_oe_r <= 1'b0;
        end
        else
        begin
            irq_p_r    <= irq_request;
            irq_s_r    <= irq_request;
            irq_p_oe_r <= irq_line_enable_bit && !win_sel;   // see [R8] see [R10]
            irq_s_oe_r <= irq_line_enable_bit && win_sel;    // see [R9] see [R10]
        end
    end

    // events: accepted access, refused access, rising interrupt request
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            irq_req_d_r <= 1'b0;
        else
            irq_req_d_r <= irq_request;
    end

    assign ev_set[host_port_pkg::EV_HIT]     = access_ok && !sel_r;
    assign ev_set[host_port_pkg::EV_REFUSED] = refused;
    assign ev_set[host_port_pkg::EV_IRQ]     = irq_request && !irq_req_d_r;

    // apb: one wait state, so pready and read data come from flops
    assign apb_access  = psel && penable && !pready_r;
    assign apb_done    = psel && penable && pready_r;
    assign addr_mapped = (paddr == host_port_pkg::OFF_STRAP) || (paddr == host_port_pkg::OFF_CTRL)
                      || (paddr == host_port_pkg::OFF_IRQ_STATUS)
                      || (paddr == host_port_pkg::OFF_IRQ_CLEAR)
                      || (paddr == host_port_pkg::OFF_IRQ_ENABLE);
    assign ev_clr      = (apb_done && pwrite && paddr == host_port_pkg::OFF_IRQ_CLEAR)
                       ? pwdata[host_port_pkg::EV_W-1:0] : '0;

    always_comb
    begin
        rd_mux = 32'h0;
        case (paddr)
            host_port_pkg::OFF_STRAP:      rd_mux = {24'h0, ext_sel_n, high_q, dma, win_sel,
                                                     dec_en, tr_ovr, cd_ovr, sel_r};
            host_port_pkg::OFF_CTRL:       rd_mux = ctrl_r;
            host_port_pkg::OFF_IRQ_STATUS: rd_mux = {29'h0, irq_status_r};
            host_port_pkg::OFF_IRQ_ENABLE: rd_mux = {29'h0, irq_enable_r};
            default:                       rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end
        else
        begin
            pready_r  <= apb_access;
            pslverr_r <= apb_access && !addr_mapped;
            prdata_r  <= (apb_access && !pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_r       <= host_port_pkg::CTRL_RST;
            irq_enable_r <= host_port_pkg::IRQ_EN_RST;
        end
        else if (apb_done && pwrite)
        begin
            if (paddr == host_port_pkg::OFF_CTRL)
                ctrl_r <= {31'h0, pwdata[host_port_pkg::CTRL_DECODE_EN]};
            if (paddr == host_port_pkg::OFF_IRQ_ENABLE)
                irq_enable_r <= pwdata[host_port_pkg::EV_W-1:0];
        end
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            irq_status_r <= '0;
        else
            irq_status_r <= (irq_status_r & ~ev_clr) | ev_set;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            irq_r <= 1'b0;
        else
            irq_r <= |(((irq_status_r & ~ev_clr) | ev_set) & irq_enable_r);
    end

    assign prdata               = prdata_r;
    assign pready               = pready_r;
    assign pslverr              = pslverr_r;
    assign carrier_detect_bit   = cd_bit_r;
    assign terminal_ready_bit   = tr_bit_r;
    assign host_reg_select      = sel_r;
    assign host_reg_index       = index_r;
    assign irq_out_primary      = irq_p_r;
    assign irq_out_primary_oe   = irq_p_oe_r;
    assign irq_out_secondary    = irq_s_r;
    assign irq_out_secondary_oe = irq_s_oe_r;
    assign irq                  = irq_r;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence cd_follow_s;
        !cd_ovr ##0 $stable(ctrl_carrier_detect);
    endsequence

    // apb answer: ready one cycle after the access phase starts, then gone again
    sequence apb_answer_s;
        pready ##1 !pready;
    endsequence

    AST_CD_FOLLOWS: assert property (cd_follow_s // see [R1]
        |=> carrier_detect_bit == $past(ctrl_carrier_detect))
        else $error("carrier detect bit does not follow controller value");
    AST_CD_FORCED: assert property (cd_ovr |=> carrier_detect_bit) // see [R2]
        else $error("carrier detect bit not forced to one");
    AST_TR_FOLLOWS: assert property (!tr_ovr // see [R3]
        |=> terminal_ready_bit == $past(host_terminal_ready))
        else $error("terminal ready bit does not follow host value");
    AST_TR_FORCED: assert property (tr_ovr |=> terminal_ready_bit) // see [R4]
        else $error("terminal ready bit not forced to one");
    AST_EXT_SELECT: assert property (!dec_en && ext_sel_n |=> !host_reg_select) // see [R5]
        else $error("external decode accepted without select");
    AST_INT_DECODE: assert property (dec_en && !window_hit(addr, win_sel) // see [R6]
        |=> !host_reg_select)
        else $error("internal decoder accepted outside window");
    AST_PRIMARY_PIN: assert property (!win_sel |=> !irq_out_secondary_oe) // see [R8]
        else $error("secondary interrupt pin driven with window select low");
    AST_SECONDARY_PIN: assert property (win_sel |=> !irq_out_primary_oe) // see [R9]
        else $error("primary interrupt pin driven with window select high");
    AST_LINE_ENABLE: assert property ((irq_out_primary_oe || irq_out_secondary_oe) // see [R10]
        |-> $past(irq_line_enable_bit))
        else $error("interrupt pin driven with line enable clear");
    AST_DMA_BLOCK: assert property (dma |=> !host_reg_select) // see [R11]
        else $error("decode during dma cycle");
    AST_HIGHQ_BLOCK: assert property (!high_q |=> !host_reg_select) // see [R12]
        else $error("decode without high address qualifier");
    AST_INDEX: assert property (host_reg_select // see [R13]
        |-> host_reg_index == $past(addr[2:0]))
        else $error("register index does not match low address lines");
    AST_INDEX_IDLE: assert property (!host_reg_select |-> host_reg_index == 3'h0)
        else $error("register index not zero while deselected");
    AST_CTRL_BLOCK: assert property (!ctrl_r[host_port_pkg::CTRL_DECODE_EN] |=> !host_reg_select)
        else $error("host access decoded with decode enable clear");
    AST_PIN_VALUE: assert property (irq_request |=> irq_out_primary && irq_out_secondary)
        else $error("interrupt pin value does not follow the request");
    AST_APB_WAIT: assert property (apb_access |=> apb_answer_s)
        else $error("apb ready not one cycle after the access phase");
    AST_UNMAPPED: assert property (apb_access && !addr_mapped |=> pslverr)
        else $error("unmapped apb address without error response");
    AST_READ_IDLE: assert property (!apb_access |=> prdata == 32'h0)
        else $error("read data not zero outside the answer cycle");
    // a new event is never lost to a clear written in the same cycle
    AST_SET_WINS: assert property (ev_set != '0
        |=> (irq_status_r & $past(ev_set)) == $past(ev_set))
        else $error("status event lost");
    // with the enable unchanged the level is exactly enabled and set
    AST_IRQ_LEVEL: assert property ($stable(irq_enable_r)
        |-> irq == |(irq_status_r & irq_enable_r))
        else $error("interrupt level does not match enabled status");

endmodule

// ### test/host_bus_model.sv
// behavioural host cpu bus driving the io strobes and address lines
`timescale 1ns/1ps
module host_bus_model
(
    input  wire logic       ref_clk,
    input  wire logic       tie_upper,
    output logic            host_rd_n,
    output logic            host_wr_n,
    output logic [9:0]      host_addr
);
    initial
    begin
        host_rd_n = 1'b1;
        host_wr_n = 1'b1;
        host_addr = 10'h000;
    end
    // one i/o cycle, held until end_cycle is called
    task automatic start(input logic [9:0] a, input logic rd);
        @(posedge ref_clk);
        host_addr <= tie_upper ? {host_addr[9:3], a[2:0]} : a;
        {host_rd_n, host_wr_n} <= {~rd, rd};
    endtask
    // released lines show the inverse (only lines 2..0 while tie_upper is high) so a stale address cannot match by luck
    task automatic end_cycle();
        @(posedge ref_clk);
        {host_rd_n, host_wr_n} <= 2'h3;
        host_addr <= tie_upper ? {host_addr[9:3], ~host_addr[2:0]} : ~host_addr;
    endtask
endmodule

// ### test/testbench.sv
// self-checking bench for the host port decode and status override block
`timescale 1ns/1ps
module testbench;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic        cd_ovr = 1'b1, tr_ovr = 1'b1, dec_en = 1'b1, win_sel = 1'b1;
    logic        dma = 1'b0, high_q = 1'b1, ext_sel_n = 1'b1;
    logic        ctrl_cd = 1'b0, host_tr = 1'b0, line_en = 1'b0, irq_req = 1'b0;
    logic        rd_n, wr_n, cd_bit, tr_bit, sel, p_irq, p_oe, s_irq, s_oe, irq;
    logic [9:0]  haddr, a;
    logic [2:0]  idx;
    logic        e;
    int          errors = 0;
    int          samples_checked = 0;

    always #12.5 ref_clk = ~ref_clk;

    host_bus_model host (.ref_clk(ref_clk), .tie_upper(~dec_en), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .host_addr(haddr));
    host_port_decode dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .carrier_detect_override(cd_ovr), .terminal_ready_override(tr_ovr),
        .internal_decoder_enable(dec_en), .port_window_select(win_sel), .dma_bus_owner(dma),
        .high_address_qualify(high_q), .ext_select_n(ext_sel_n), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .host_addr(haddr), .ctrl_carrier_detect(ctrl_cd),
        .host_terminal_ready(host_tr), .irq_line_enable_bit(line_en), .irq_request(irq_req),
        .carrier_detect_bit(cd_bit), .terminal_ready_bit(tr_bit), .host_reg_select(sel),
        .host_reg_index(idx), .irq_out_primary(p_irq), .irq_out_primary_oe(p_oe),
        .irq_out_secondary(s_irq), .irq_out_secondary_oe(s_oe), .irq(irq));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // apb master: request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, ad, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        chk("apb wait states", 32'h2, 32'(n));
        {psel, penable} <= 2'h0;
    endtask

    // pins pass two sync flops plus the output register
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic exp_sel(input logic [9:0] ad);
        logic [6:0] base;
        base = win_sel ? host_port_pkg::WIN_BASE_SECONDARY : host_port_pkg::WIN_BASE_PRIMARY;
        return (dec_en ? ad[9:3] == base : ~ext_sel_n) & ~dma & high_q;
    endfunction

    initial
    begin
        repeat (10000) @(posedge ref_clk);
        chk("watchdog", 32'h0, 32'h1);
        give_verdict();
    end

    initial
    begin
        void'($urandom(92771));
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        settle();
        chk("primary_oe", 1'b0, p_oe);
        apb(1'b0, host_port_pkg::OFF_CTRL, 32'h0);
        chk("ctrl", host_port_pkg::CTRL_RST, rd);
        apb(1'b0, host_port_pkg::OFF_IRQ_ENABLE, 32'h0);
        chk("irq_enable", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("pslverr", 32'h1, err);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            {cd_ovr, ctrl_cd, tr_ovr, host_tr} <= {i[0], i[1], i[2], 1'($urandom)};
            settle();
            chk("carrier_detect_bit", cd_ovr ? 1'b1 : ctrl_cd, cd_bit);
            chk("terminal_ready_bit", tr_ovr ? 1'b1 : host_tr, tr_bit);
        end
        $display("test overrides done");
        for (int i = 0; i < 48; i++)
        begin
            @(posedge ref_clk);
            {dec_en, win_sel, ext_sel_n} <= 3'($urandom);
            dma <= ($urandom % 4 == 0);
            high_q <= ($urandom % 4 != 0);
            a = (i % 3 == 0) ? {host_port_pkg::WIN_BASE_PRIMARY, 3'(i)} :
                (i % 3 == 1) ? {host_port_pkg::WIN_BASE_SECONDARY, 3'(i)} : 10'($urandom);
            if (i == 5)
                a = 10'h3f7;
            if (i == 8)
                a = 10'h300;
            host.start(a, 1'($urandom));
            settle();
            e = exp_sel(a);
            chk("host_reg_select", e, sel);
            chk("host_reg_index", e ? a[2:0] : 3'h0, idx);
            apb(1'b0, host_port_pkg::OFF_STRAP, 32'h0);
            chk("strap", {ext_sel_n, high_q, dma, win_sel, dec_en, tr_ovr, cd_ovr, e}, rd);
            host.end_cycle();
            settle();
            chk("host_reg_select idle", 1'b0, sel);
        end
        @(posedge ref_clk);
        {dec_en, win_sel, dma, high_q} <= 4'b1001;
        apb(1'b1, host_port_pkg::OFF_CTRL, 32'h0);
        host.start({host_port_pkg::WIN_BASE_PRIMARY, 3'h1}, 1'b1);
        settle();
        chk("select blocked", 1'b0, sel);
        host.end_cycle();
        apb(1'b1, host_port_pkg::OFF_CTRL, 32'h1);
        $display("test decode done");
        for (int i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            {line_en, win_sel, irq_req} <= 3'(i);
            settle();
            chk("primary_oe", line_en & ~win_sel, p_oe);
            chk("secondary_oe", line_en & win_sel, s_oe);
            chk("pin value", {irq_req, irq_req}, {p_irq, s_irq});
        end
        $display("test irq pins done");
        @(posedge ref_clk);
        {win_sel, irq_req} <= 2'h0;
        apb(1'b1, host_port_pkg::OFF_IRQ_CLEAR, 32'h7);
        apb(1'b1, host_port_pkg::OFF_IRQ_ENABLE, 32'h1 << host_port_pkg::EV_HIT);
        host.start({host_port_pkg::WIN_BASE_PRIMARY, 3'h2}, 1'b0);
        settle();
        chk("irq raised", 1'b1, irq);
        apb(1'b1, host_port_pkg::OFF_IRQ_ENABLE, 32'h0);
        settle();
        chk("irq masked", 1'b0, irq);
        apb(1'b1, host_port_pkg::OFF_IRQ_ENABLE, 32'h1 << host_port_pkg::EV_HIT);
        host.end_cycle();
        settle();
        chk("irq unmasked", 1'b1, irq);
        apb(1'b1, host_port_pkg::OFF_IRQ_CLEAR, 32'h1 << host_port_pkg::EV_HIT);
        settle();
        chk("irq cleared", 1'b0, irq);
        apb(1'b0, host_port_pkg::OFF_IRQ_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        $display("test interrupt done");
        @(posedge ref_clk);
        {irq_req, dma} <= 2'b11;
        host.start({host_port_pkg::WIN_BASE_PRIMARY, 3'h3}, 1'b1);
        settle();
        chk("select during dma", 1'b0, sel);
        apb(1'b0, host_port_pkg::OFF_IRQ_STATUS, 32'h0);
        chk("status events", (32'h1 << host_port_pkg::EV_REFUSED)
            | (32'h1 << host_port_pkg::EV_IRQ), rd);
        apb(1'b1, host_port_pkg::OFF_IRQ_CLEAR, 32'h7);
        apb(1'b0, host_port_pkg::OFF_IRQ_STATUS, 32'h0);
        chk("status set wins", 32'h1 << host_port_pkg::EV_REFUSED, rd);
        host.end_cycle();
        dma <= 1'b0;
        settle();
        apb(1'b1, host_port_pkg::OFF_IRQ_CLEAR, 32'h7);
        apb(1'b0, host_port_pkg::OFF_IRQ_STATUS, 32'h0);
        chk("status cleared", 32'h0, rd);
        $display("test events done");
        give_verdict();
    end
endmodule
